/* ppl_map.vh */
// Purpose: Constants for the parallel port lines block: offsets, fields, masks, timing.
// Assumes: A 50 MHz pclk and APB with one 32-bit word per register.
// Notes:   Included by bare name; definitions only.
`ifndef PPL_MAP_VH
`define PPL_MAP_VH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PPL_CLK_PERIOD_NS   20
`define PPL_STATE_TIME_NS   40
`define PPL_STATE_CYCLES    (((`PPL_STATE_TIME_NS / `PPL_CLK_PERIOD_NS) < 1) ? 1 : \
                             (`PPL_STATE_TIME_NS / `PPL_CLK_PERIOD_NS))

// ----------------------------------------------------------------------------
// Address map: group base is group index times 0x20, register word in bits 4:2
// ----------------------------------------------------------------------------
`define PPL_GRP_LSB         5
`define PPL_GRP_STRIDE      12'h020
`define PPL_NUM_GRP         4'd11
`define PPL_REG_DATA        3'd0
`define PPL_REG_DIR         3'd1
`define PPL_REG_DRAIN       3'd2
`define PPL_REG_SET         3'd3
`define PPL_REG_CLR         3'd4
`define PPL_THRESH_ADDR     12'h160
`define PPL_EXT_THRESH_ADDR 12'h164

// Group indices: port0 low/high, port1 low/high, then ports 2..8.
`define PPL_GRP_P0L         4'd0
`define PPL_GRP_P0H         4'd1
`define PPL_GRP_P1L         4'd2
`define PPL_GRP_P1H         4'd3
`define PPL_GRP_P2          4'd4

// ----------------------------------------------------------------------------
// Per port capabilities, port n in bits 16n+15:16n (masks) or bit n (flags)
// ----------------------------------------------------------------------------
`define PPL_IMPL_MASKS      {16'h00ff, 16'h00ff, 16'h00ff, 16'hffff, 16'h00ff, \
                             16'hbfff, 16'hffff, 16'hffff, 16'hffff}
`define PPL_OUT_CAP         9'h1df
`define PPL_DRAIN_CAP       9'h1dc

// ----------------------------------------------------------------------------
// Threshold select fields and reset values
// ----------------------------------------------------------------------------
`define PPL_THRESH_BITS     13
`define PPL_THRESH_RESET    13'h0000
`define PPL_EXT_THRESH_BITS 1
`define PPL_EXT_THRESH_RESET 1'h0

`endif

/* ppl_parallel_port.v */
// Purpose: APB register front end and pin array for the nine parallel ports.
// Assumes: Pins are synchronous to pclk; the pad applies the threshold select.
// Notes:   Zero wait state slave; unmapped addresses answer with pslverr.
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/10ps
`include "ppl_map.vh"

// Contract
// - Every pin is sampled into its input latch once per state time.
// - Writing an input pin updates only its output latch; pin stays undriven.
// - Reading an input pin returns the sampled pin level.
// - Modify of an input pin starts from sampled level, result into latch.
// - Direction one: write loads the latch and the pin is driven with it.
// - Reading an output pin returns the output latch.
// - Modify of an output pin starts from the latch and drives the result.
// - Ports 2,3,4,6,7,8 select push-pull or open drain per bit.
// - Ports 0 and 1 are two separately addressed byte halves each.
// - Port 2 has sixteen lines, port 4 eight, all bidirectional.
// - Port 3 has fifteen lines; bit fourteen has no storage or pin.
// - Port 5 has sixteen input only lines with no output latch.
// - Ports 6, 7 and 8 have eight bidirectional lines each.
// - At most 111 general purpose lines exist over all ports.
// - Inputs default to the TTL threshold and can switch to CMOS.
// - Threshold is chosen per byte; ports 2, 3, 5 take two bits.
// - Direction and drive mode work whatever threshold is chosen.
// - All pins come out of reset as inputs.
// - With an alternate output the pin is latch AND alternate data.
// - An output pin feeds its latch value to its alternate input.
module ppl_parallel_port (
    input  wire         pclk,
    input  wire         presetn,
    input  wire         psel,
    input  wire         penable,
    input  wire         pwrite,
    input  wire [11:0]  paddr,
    input  wire [31:0]  pwdata,
    output wire         pready,
    output reg  [31:0]  prdata,
    output reg          pslverr,
    input  wire [143:0] pin_in,
    output wire [143:0] pin_out,
    output wire [143:0] pin_oe,
    input  wire [143:0] alt_out_en,
    input  wire [143:0] alt_out_data,
    output wire [143:0] alt_in,
    output wire [13:0]  cmos_sel
);

    localparam [143:0] IMPL_ALL  = `PPL_IMPL_MASKS;
    localparam [8:0]   OUT_ALL   = `PPL_OUT_CAP;
    localparam [8:0]   DRAIN_ALL = `PPL_DRAIN_CAP;

    wire         tick;
    wire [143:0] view_all;
    wire [143:0] dir_all;
    wire [143:0] drain_all;
    reg  [17:0]  slice_we;
    reg  [2:0]   wsel;
    reg  [15:0]  wdata16;
    reg  [3:0]   slice_idx;
    reg  [1:0]   lane;
    reg          port_hit;
    reg          thr_hit;
    reg          ext_hit;
    reg  [31:0]  read_word;
    reg  [15:0]  raw16;
    reg  [`PPL_THRESH_BITS-1:0]     threshold_select_control;
    reg  [`PPL_EXT_THRESH_BITS-1:0] ext_threshold_select_control;
    wire [3:0]   grp;
    wire [2:0]   rsel;
    wire         setup;
    wire         wr_commit;

    assign grp       = paddr[8:5];
    assign rsel      = paddr[4:2];
    assign setup     = psel & ~penable;
    assign wr_commit = psel & penable & pwrite;

    // The slave never stretches the access phase.
    assign pready = 1'b1;

    // ------------------------------------------------------------------------
    // State time divider
    // ------------------------------------------------------------------------
    ppl_state_tick u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick)
    );

    // ------------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------------
    // Groups 0 to 3 are the byte halves of ports 0 and 1, then one per port.
    always @* begin
        port_hit  = 1'b0;
        thr_hit   = 1'b0;
        ext_hit   = 1'b0;
        slice_idx = 4'h0;
        lane      = 2'b00;
        if (paddr[1:0] != 2'b00 || paddr[11:9] != 3'b000) begin
            port_hit = 1'b0;
        end else if (paddr == `PPL_THRESH_ADDR) begin
            thr_hit = 1'b1;
        end else if (paddr == `PPL_EXT_THRESH_ADDR) begin
            ext_hit = 1'b1;
        end else if (grp < `PPL_GRP_P2) begin
            port_hit  = (rsel <= `PPL_REG_CLR);
            slice_idx = {3'b000, grp[1]};
            lane      = grp[0] ? 2'b10 : 2'b01;
        end else if (grp < `PPL_NUM_GRP) begin
            port_hit  = (rsel <= `PPL_REG_CLR);
            slice_idx = grp - 4'd2;
            lane      = 2'b11;
        end
    end

    // ------------------------------------------------------------------------
    // Write steering
    // ------------------------------------------------------------------------
    // A high half takes its byte from the low lane of pwdata.
    always @* begin
        slice_we = 18'h00000;
        wsel     = rsel;
        wdata16  = (lane == 2'b10) ? {pwdata[7:0], 8'h00} : pwdata[15:0];
        if (wr_commit && port_hit) begin
            slice_we[{slice_idx, 1'b0} +: 2] = lane;
        end
    end

    // ------------------------------------------------------------------------
    // Port slices
    // ------------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 9; gi = gi + 1) begin : g_port
            ppl_port_slice #(
                .IMPL      (IMPL_ALL[gi*16 +: 16]),
                .OUT_CAP   (OUT_ALL[gi] ? 1 : 0),
                .DRAIN_CAP (DRAIN_ALL[gi] ? 1 : 0)
            ) u_slice (
                .pclk               (pclk),
                .presetn            (presetn),
                .tick               (tick),
                .we                 (slice_we[gi*2 +: 2]),
                .wsel               (wsel),
                .wdata              (wdata16),
                .pin_in             (pin_in[gi*16 +: 16]),
                .alt_out_en         (alt_out_en[gi*16 +: 16]),
                .alt_out_data       (alt_out_data[gi*16 +: 16]),
                .view               (view_all[gi*16 +: 16]),
                .pin_direction_bit  (dir_all[gi*16 +: 16]),
                .drain_mode_control (drain_all[gi*16 +: 16]),
                .pin_out            (pin_out[gi*16 +: 16]),
                .pin_oe             (pin_oe[gi*16 +: 16]),
                .alt_in             (alt_in[gi*16 +: 16])
            );
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Threshold select registers
    // ------------------------------------------------------------------------
    // Reset selects TTL everywhere; the pads only see these bits.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            threshold_select_control     <= `PPL_THRESH_RESET;
            ext_threshold_select_control <= `PPL_EXT_THRESH_RESET;
        end else if (wr_commit && thr_hit) begin
            threshold_select_control <= pwdata[`PPL_THRESH_BITS-1:0];
        end else if (wr_commit && ext_hit) begin
            ext_threshold_select_control <= pwdata[`PPL_EXT_THRESH_BITS-1:0];
        end
    end

    // Threshold choice feeds the pads only, never the direction or drive logic.
    assign cmos_sel = {ext_threshold_select_control, threshold_select_control};

    // ------------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------------
    // Set and clear words read back the same view as the data word.
    always @* begin
        read_word = 32'h00000000;
        raw16     = 16'h0000;
        if (rsel == `PPL_REG_DIR) begin
            raw16 = dir_all[slice_idx*16 +: 16];
        end else if (rsel == `PPL_REG_DRAIN) begin
            raw16 = drain_all[slice_idx*16 +: 16];
        end else begin
            raw16 = view_all[slice_idx*16 +: 16];
        end
        if (thr_hit) begin
            read_word = {19'h00000, threshold_select_control};
        end else if (ext_hit) begin
            read_word = {31'h00000000, ext_threshold_select_control};
        end else if (port_hit && lane == 2'b01) begin
            read_word = {24'h000000, raw16[7:0]};
        end else if (port_hit && lane == 2'b10) begin
            read_word = {24'h000000, raw16[15:8]};
        end else if (port_hit) begin
            read_word = {16'h0000, raw16};
        end
    end

    // Read data and error are captured in the setup cycle for the access phase.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata  <= pwrite ? 32'h00000000 : read_word;
            pslverr <= ~(port_hit | thr_hit | ext_hit);
        end
    end

endmodule

/* ppl_parallel_port_properties.sv */
// Purpose: Port level assertions for the parallel port block.
// Assumes: Pins are sampled every second pclk; the APB slave has no wait states.
// Notes:   Bound to every instance of the block; prints only on a failure.
`timescale 1ns/10ps
module ppl_props (
    input wire         pclk,
    input wire         presetn,
    input wire         psel,
    input wire         penable,
    input wire         pwrite,
    input wire [11:0]  paddr,
    input wire [31:0]  pwdata,
    input wire         pready,
    input wire [31:0]  prdata,
    input wire         pslverr,
    input wire [143:0] pin_in,
    input wire [143:0] pin_out,
    input wire [143:0] pin_oe,
    input wire [143:0] alt_out_en,
    input wire [143:0] alt_out_data,
    input wire [143:0] alt_in,
    input wire [13:0]  cmos_sel
);
    // ----------------------------------------------------------------
    // Clocking and shared sequences
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // A write that commits to one register word.
    sequence s_wr(logic [11:0] a);
        psel && penable && pwrite && paddr == a;
    endsequence
    // The setup cycle of a read, when read data gets loaded.
    sequence s_rd;
        psel && !penable && !pwrite;
    endsequence
    // Two edges without change, so one sample tick has certainly seen the level.
    sequence s_p5_still;
        $stable(pin_in[95:80]) [*2];
    endsequence
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    AST_P5_INPUT: assert property (pin_oe[95:80] == 16'h0)
        else $error("port five drove a pin");
    AST_P3_GAP: assert property (!pin_oe[62])
        else $error("missing port three line was driven");
    AST_BYTE_PORTS: assert property ({pin_oe[143:136], pin_oe[127:120],
        pin_oe[111:104], pin_oe[79:72]} == 32'h0)
        else $error("upper half of a byte port was driven");
    AST_LATCH_FEED: assert property (((alt_in ^ pin_out) & pin_oe & ~alt_out_en) == 144'h0)
        else $error("alternate input differs from the driven latch");
    AST_ALT_AND: assert property ((pin_out & pin_oe & alt_out_en & ~alt_out_data) == 144'h0)
        else $error("pin high while alternate data is low");
    AST_RESET_IN: assert property ($rose(presetn) |-> pin_oe == 144'h0 && cmos_sel == 14'h0)
        else $error("pins or thresholds not at reset state");
    // The first sample tick comes a few edges after release, so early attempts are skipped.
    AST_SAMPLE: assert property ($past(presetn, 3) ##0 s_p5_still |=>
        alt_in[95:80] == $past(pin_in[95:80]))
        else $error("steady input level not sampled in time");
    AST_HALF_READ: assert property (s_rd ##0 paddr < 12'h080 |=> prdata[31:8] == 24'h0)
        else $error("byte half read beyond its eight bits");
    AST_THRESH: assert property (s_wr(12'h160) |=> cmos_sel[12:0] == $past(pwdata[12:0]))
        else $error("threshold selects did not follow the write");
    AST_EXT_THRESH: assert property (s_wr(12'h164) |=> cmos_sel[13] == $past(pwdata[0]))
        else $error("extended threshold select did not follow the write");
endmodule

bind ppl_parallel_port ppl_props u_props (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .prdata, .pslverr, .pin_in, .pin_out, .pin_oe,
    .alt_out_en, .alt_out_data, .alt_in, .cmos_sel);

/* ppl_pin_model.sv */
// Purpose: External circuit on the port pins.
// Assumes: Every line carries a pull-up resistor.
// Notes:   Outside drivers are switched on and off by the testbench.
`timescale 1ns/10ps
module ppl_pin_model (
    input  wire [143:0] pin_out,
    input  wire [143:0] pin_oe,
    input  wire [143:0] ext_drv,
    input  wire [143:0] ext_en,
    output wire [143:0] pin_in
);
    // A released line floats up to one; two drivers resolve as a wired AND,
    // which is what an open drain line with a pull-up gives.
    assign pin_in = (~pin_oe | pin_out) & (~ext_en | ext_drv);
endmodule

/* ppl_port_slice.v */
// Purpose: One 16-bit parallel port: latches, direction, drain mode and pin drive.
// Assumes: Byte lane enables come from the register decoder in the top.
// Notes:   Unimplemented bit positions hold no state and never drive.
`timescale 1ns/10ps
`include "ppl_map.vh"

module ppl_port_slice #(
    parameter [15:0] IMPL      = 16'hffff,
    parameter        OUT_CAP   = 1,
    parameter        DRAIN_CAP = 1
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        tick,
    input  wire [1:0]  we,
    input  wire [2:0]  wsel,
    input  wire [15:0] wdata,
    input  wire [15:0] pin_in,
    input  wire [15:0] alt_out_en,
    input  wire [15:0] alt_out_data,
    output wire [15:0] view,
    output reg  [15:0] pin_direction_bit,
    output reg  [15:0] drain_mode_control,
    output wire [15:0] pin_out,
    output wire [15:0] pin_oe,
    output wire [15:0] alt_in
);

    reg  [15:0] out_latch;
    reg  [15:0] in_latch;
    wire [15:0] lane_mask;
    wire [15:0] out_mask;
    wire [15:0] drive_val;
    reg  [15:0] next_out_latch;

    assign lane_mask = {{8{we[1]}}, {8{we[0]}}} & IMPL;
    assign out_mask  = OUT_CAP ? lane_mask : 16'h0000;

    // ------------------------------------------------------------------------
    // Read view
    // ------------------------------------------------------------------------
    // Input bits show the sampled pin, output bits show the latch.
    assign view = (pin_direction_bit & out_latch) | (~pin_direction_bit & in_latch);

    // Alternate input sees the latch when the pin is an output.
    assign alt_in = view;

    // ------------------------------------------------------------------------
    // Output latch next value
    // ------------------------------------------------------------------------
    // Set and clear take the read view, so an input bit copies its pin level.
    always @* begin
        next_out_latch = out_latch;
        if (wsel == `PPL_REG_DATA) begin
            next_out_latch = (out_latch & ~out_mask) | (wdata & out_mask);
        end else if (wsel == `PPL_REG_SET) begin
            next_out_latch = (out_latch & ~out_mask) | ((view | wdata) & out_mask);
        end else if (wsel == `PPL_REG_CLR) begin
            next_out_latch = (out_latch & ~out_mask) | ((view & ~wdata) & out_mask);
        end
    end

    // ------------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------------
    // All bits come out of reset as inputs with the latches cleared.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_latch          <= 16'h0000;
            in_latch           <= 16'h0000;
            pin_direction_bit  <= 16'h0000;
            drain_mode_control <= 16'h0000;
        end else begin
            if (tick) begin
                in_latch <= pin_in & IMPL;
            end
            out_latch <= next_out_latch;
            if (wsel == `PPL_REG_DIR) begin
                pin_direction_bit <= (pin_direction_bit & ~out_mask) | (wdata & out_mask);
            end
            if (wsel == `PPL_REG_DRAIN && DRAIN_CAP != 0) begin
                drain_mode_control <= (drain_mode_control & ~out_mask) | (wdata & out_mask);
            end
        end
    end

    // ------------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------------
    // An alternate output is gated by the latch, so the latch should hold one.
    assign drive_val = out_latch & (~alt_out_en | alt_out_data);

    // Open drain pulls low on zero and floats on one; push-pull always drives.
    assign pin_oe  = pin_direction_bit & (~drain_mode_control | ~drive_val) & IMPL;
    assign pin_out = drive_val & ~drain_mode_control & pin_oe;

endmodule

/* ppl_state_tick.v */
// Purpose: Divides pclk down to a one-cycle pulse once per state time.
// Assumes: The state time is a whole number of pclk periods.
// Notes:   Free running from reset release.
`timescale 1ns/10ps
`include "ppl_map.vh"

module ppl_state_tick (
    input  wire       pclk,
    input  wire       presetn,
    output reg        tick
);

    reg  [3:0] count;
    wire       at_end;

    // ------------------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------------------
    // The 32-bit comparison avoids truncating the derived cycle count.
    assign at_end = ({28'h0000000, count} == (`PPL_STATE_CYCLES - 1));

    // Count one state time; tick is high in the cycle after its last one.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 4'h0;
            tick  <= 1'b0;
        end else if (at_end) begin
            count <= 4'h0;
            tick  <= 1'b1;
        end else begin
            count <= count + 4'h1;
            tick  <= 1'b0;
        end
    end

endmodule

/* testbench.sv */
// Purpose: Self checking bench for the parallel port block.
// Assumes: APB slave without wait states; state time of two pclk cycles.
// Notes:   Pins are resolved by the external circuit model.
`timescale 1ns/10ps
module testbench;
    reg          pclk;
    reg          presetn;
    reg          psel;
    reg          penable;
    reg          pwrite;
    reg  [11:0]  paddr;
    reg  [31:0]  pwdata;
    wire         pready;
    wire [31:0]  prdata;
    wire         pslverr;
    wire [143:0] pin_in;
    wire [143:0] pin_out;
    wire [143:0] pin_oe;
    reg  [143:0] alt_out_en;
    reg  [143:0] alt_out_data;
    wire [143:0] alt_in;
    wire [13:0]  cmos_sel;
    reg  [143:0] ext_drv;
    reg  [143:0] ext_en;
    reg  [31:0]  rd;
    reg          err;
    integer      n_fail;
    integer      check_count;
    integer      g;

    // ----------------------------------------------------------------
    // Design, pins and clock
    // ----------------------------------------------------------------
    ppl_parallel_port i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pready, .prdata, .pslverr, .pin_in, .pin_out, .pin_oe,
        .alt_out_en, .alt_out_data, .alt_in, .cmos_sel);
    ppl_pin_model i_pins (.pin_out, .pin_oe, .ext_drv, .ext_en, .pin_in);
    // Free running 50 MHz clock.
    initial pclk = 1'b0;
    always #10 pclk = ~pclk;

    // Counts a comparison and reports a mismatch at once.
    task chk(input string nm, input [31:0] e, input [31:0] v);
        begin
            check_count = check_count + 1;
            if (v !== e) begin
                n_fail = n_fail + 1;
                $display("CHECK FAILED %s expected %h seen %h", nm, e, v);
            end
        end
    endtask

    // One APB transfer; it starts on a fresh edge so no signal is set twice at once.
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1) @(posedge pclk);
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task wr(input [11:0] a, input [31:0] d);
        apb(1'b1, a, d);
    endtask

    task rdc(input string nm, input [11:0] a, input [31:0] e);
        begin
            apb(1'b0, a, 32'h0);
            chk(nm, e, rd);
        end
    endtask

    // Three edges cover one full sample tick plus the latch update; the short step
    // after the last edge lets the outputs settle before they are compared.
    task settle;
        begin
            repeat (3) @(posedge pclk);
            #1;
        end
    endtask

    task test_done;
        begin
            $display("Checks %0d, failures %0d", check_count, n_fail);
            if (n_fail == 0 && check_count > 0) begin
                $display("Run complete: PASS");
            end else begin
                $display("Run complete: FAIL");
            end
            $finish;
        end
    endtask

    // The tests need under 150 cycles; over twenty-five times that means a hang.
    initial begin
        repeat (4000) @(posedge pclk);
        n_fail = n_fail + 1;
        test_done;
    end

    // Main sequence of register calls and pin checks.
    initial begin
        n_fail = 0;
        check_count = 0;
        {presetn, psel, penable, pwrite, paddr, pwdata} = 48'h0;
        {alt_out_en, alt_out_data, ext_drv, ext_en} = 576'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdc("p2 dir", 12'h084, 32'h0);
        rdc("threshold", 12'h160, 32'h0);
        ext_en[47:32] <= 16'hffff;
        ext_drv[47:32] <= 16'h3c3c;
        wr(12'h080, 32'ha5a5);
        settle;
        chk("p2 oe", 32'h0, {16'h0, pin_oe[47:32]});
        rdc("p2 in", 12'h080, 32'h3c3c);
        wr(12'h08c, 32'h0001);
        ext_en[47:32] <= 16'h0;
        wr(12'h084, 32'hffff);
        settle;
        chk("p2 pins", 32'h3c3d, {16'h0, pin_in[47:32]});
        rdc("p2 latch", 12'h080, 32'h3c3d);
        wr(12'h090, 32'h0005);
        settle;
        chk("p2 pins", 32'h3c38, {16'h0, pin_in[47:32]});
        wr(12'h160, 32'h1fff);
        wr(12'h164, 32'h0001);
        settle;
        chk("cmos", 32'h3fff, {18'h0, cmos_sel});
        // Open drain low byte with the far side pulling it low.
        wr(12'h088, 32'h00ff);
        ext_en[39:32] <= 8'hff;
        ext_drv[39:32] <= 8'h00;
        settle;
        chk("p2 oe", 32'hffc7, {16'h0, pin_oe[47:32]});
        chk("p2 pins", 32'h3c00, {16'h0, pin_in[47:32]});
        rdc("p2 latch", 12'h080, 32'h3c38);
        alt_out_en[42] <= 1'b1;
        settle;
        chk("alt pin", 32'h0, {31'h0, pin_in[42]});
        chk("alt in", 32'h1, {31'h0, alt_in[42]});
        wr(12'h004, 32'hff);
        wr(12'h000, 32'h123456ab);
        wr(12'h024, 32'hff);
        wr(12'h020, 32'h5a);
        settle;
        chk("p0 pins", 32'h5aab, {16'h0, pin_in[15:0]});
        rdc("p0 low", 12'h000, 32'hab);
        rdc("p0 high", 12'h020, 32'h5a);
        // Port 0 has no open drain control, so the write is dropped.
        wr(12'h008, 32'hff);
        rdc("p0 drain", 12'h008, 32'h0);
        wr(12'h0a4, 32'hffff);
        wr(12'h0a0, 32'hffff);
        settle;
        chk("p3 oe", 32'hbfff, {16'h0, pin_oe[63:48]});
        rdc("p3 latch", 12'h0a0, 32'hbfff);
        wr(12'h0e4, 32'hffff);
        rdc("p5 dir", 12'h0e4, 32'h0);
        ext_en[95:80] <= 16'hffff;
        ext_drv[95:80] <= 16'h1357;
        wr(12'h0e0, 32'hffff);
        settle;
        chk("p5 oe", 32'h0, {16'h0, pin_oe[95:80]});
        rdc("p5 in", 12'h0e0, 32'h1357);
        // Byte ports 4, 6, 7 and 8 keep only their low eight lines.
        for (g = 6; g <= 10; g = g + 1) begin
            if (g != 7) begin
                wr({g[6:0], 5'h04}, 32'hffff);
                rdc("byte dir", {g[6:0], 5'h04}, 32'hff);
            end
        end
        apb(1'b0, 12'h168, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        test_done;
    end
endmodule
